// ---- tb_thermometer_command_decoder.sv ----
// Self-checking bench for the command decoder, driven through the bus master model.
// Assumes short programming and conversion lengths set at the instance.
`timescale 1ns/1ns
module tb_thermometer_command_decoder
  import thcd_pkg::*;
;
  localparam int PROG = 200;
  localparam int CONV = 10;

  logic              mclk;
  logic              reset;
  logic              scl;
  logic              m_pull;
  logic              sda;
  logic              sda_o;
  logic              sda_oe;
  logic [2:0]        addr_pins;
  logic [TEMP_W-1:0] temp_in;
  logic              conv_active;
  logic              prog_active;
  logic [7:0]        mem_ptr;
  logic [7:0]        exp_q[$];
  int                n_mismatch;
  int                samples_checked;
  int                n_hi;
  int                seed;
  logic [7:0]        aw;
  logic [7:0]        ar;
  logic [7:0]        x;
  logic [7:0]        c;
  logic              a1;
  logic [12:0]       t;

  // Open-drain wire with pull-up
  assign sda = ~m_pull & (sda_oe ? sda_o : 1'b1);

  thcd_decoder #(.PROG_LEN(PROG), .CONV_LEN(CONV)) u_dut
  (
    .mclk        (mclk),
    .reset       (reset),
    .scl         (scl),
    .sda_i       (sda),
    .sda_o       (sda_o),
    .sda_oe      (sda_oe),
    .addr_pins   (addr_pins),
    .temp_in     (temp_in),
    .conv_active (conv_active),
    .prog_active (prog_active),
    .mem_ptr     (mem_ptr)
  );

  thcd_bus_master u_mst
  (
    .scl      (scl),
    .sda_pull (m_pull),
    .sda      (sda)
  );

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  always @(posedge mclk)
    if (conv_active === 1'b1)
      n_hi <= n_hi + 1;

  // ==========================================================
  // Checking
  task automatic cmp1(input logic g, input logic e);
    samples_checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic end_sim();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    forever
    begin
      @(u_mst.rx_ev);
      if (exp_q.size() == 0)
        cmp8(u_mst.rx_byte, 8'hxx);
      else
        cmp8(u_mst.rx_byte, exp_q.pop_front());
    end
  end

  initial
  begin
    repeat (100000) @(posedge mclk);
    n_mismatch++;
    end_sim();
  end

  // ==========================================================
  // Bus sequences
  task automatic wait_flag(input logic sel, input logic v, input int lim);
    for (int i = 0; i < lim; i++)
    begin
      @(posedge mclk);
      #1;
      if ((sel ? prog_active : conv_active) === v)
        return;
    end
    n_mismatch++;
    end_sim();
  endtask

  task automatic cmd(input logic [7:0] code);
    u_mst.start_cond();
    u_mst.wr(aw, a1);
    cmp1(a1, 1'b1);
    u_mst.wr(code, a1);
    cmp1(a1, 1'b1);
  endtask

  // Expected bytes are queued by the caller
  task automatic fetch(input logic [7:0] code, input int n);
    cmd(code);
    u_mst.start_cond();
    u_mst.wr(ar, a1);
    cmp1(a1, 1'b1);
    for (int i = 0; i < n; i++)
      u_mst.rd(i < n - 1);
    u_mst.stop_cond();
  endtask

  initial
  begin
    seed = 15820;
    n_mismatch = 0;
    samples_checked = 0;
    n_hi = 0;
    reset = 1'b1;
    addr_pins = 3'($random(seed));
    temp_in = 13'h0000;
    aw = {DEV_CODE, addr_pins, 1'b0};
    ar = aw | 8'h01;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    for (int i = 0; i < 2; i++)
    begin
      u_mst.start_cond();
      u_mst.wr(aw ^ ((i == 0) ? 8'h80 : 8'h02), a1);
      cmp1(a1, 1'b0);
      u_mst.stop_cond();
    end
    exp_q.push_back({1'b1, CFG_FIXED, 1'b0});
    fetch(CMD_CFG, 1);
    // Slow master pace for the pointer load
    x = 8'($random(seed));
    u_mst.slow = 200;
    cmd(CMD_MEM);
    u_mst.wr(x, a1);
    cmp1(a1, 1'b1);
    u_mst.stop_cond();
    u_mst.slow = 0;
    repeat (10) @(posedge mclk);
    #1;
    cmp8(mem_ptr, x);
    for (int i = 0; i < 4; i++)
    begin
      c = 8'($random(seed));
      if (c inside {CMD_MEM, CMD_CFG, CMD_TEMP, CMD_GO, CMD_HALT})
        c = c ^ 8'h01;
      n_hi = 0;
      cmd(c);
      u_mst.stop_cond();
      repeat (20) @(posedge mclk);
      #1;
      cmp1(prog_active, 1'b0);
      cmp8(mem_ptr, x);
      cmp8(8'(n_hi), 8'h00);
    end
    cmd(CMD_CFG);
    u_mst.wr(8'h01, a1);
    cmp1(a1, 1'b1);
    u_mst.stop_cond();
    u_mst.start_cond();
    u_mst.wr(aw, a1);
    cmp1(a1, 1'b0);
    u_mst.stop_cond();
    wait_flag(1'b1, 1'b0, PROG + 50);
    exp_q.push_back({1'b1, CFG_FIXED, 1'b1});
    fetch(CMD_CFG, 1);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge mclk);
      t = 13'($random(seed));
      temp_in <= t;
      n_hi = 0;
      cmd(CMD_GO);
      u_mst.stop_cond();
      repeat (4 * CONV) @(posedge mclk);
      #1;
      cmp8(8'(n_hi), 8'(CONV));
      exp_q.push_back(t[12:5]);
      exp_q.push_back({t[4:0], 3'h0});
      fetch(CMD_TEMP, 2);
    end
    cmd(CMD_CFG);
    u_mst.wr(8'h00, a1);
    cmp1(a1, 1'b1);
    u_mst.stop_cond();
    wait_flag(1'b1, 1'b0, PROG + 50);
    cmd(CMD_GO);
    u_mst.stop_cond();
    wait_flag(1'b0, 1'b1, 20);
    n_hi = 0;
    repeat (4 * CONV) @(posedge mclk);
    #1;
    cmp1(n_hi > 3 * CONV, 1'b1);
    exp_q.push_back({1'b0, CFG_FIXED, 1'b0});
    fetch(CMD_CFG, 1);
    cmd(CMD_HALT);
    u_mst.stop_cond();
    wait_flag(1'b0, 1'b0, CONV + 20);
    n_hi = 0;
    repeat (4 * CONV) @(posedge mclk);
    #1;
    cmp8(8'(n_hi), 8'h00);
    exp_q.push_back({1'b1, CFG_FIXED, 1'b0});
    fetch(CMD_CFG, 1);
    cmp8(8'(exp_q.size()), 8'h00);
    end_sim();
  end
endmodule

// ---- thcd_bus_master.sv ----
// Two-wire bus master model: makes the link clock and pulls the data wire low.
// Assumes a pull-up on the data wire; the bench resolves the wire level.
`timescale 1ns/1ns
module thcd_bus_master
(
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  // ==========================================================
  // Bit level
  int         slow;
  logic [7:0] rx_byte;
  event       rx_ev;

  initial
  begin
    scl      = 1'b1;
    sda_pull = 1'b0;
    slow     = 0;
  end

  // Data only changes while the clock is low; clock idles high outside frames
  task automatic bit_io(input logic b, output logic r);
    sda_pull = ~b;
    #(31 + slow);
    scl = 1'b1;
    r = sda;
    #63;
    scl = 1'b0;
    #31;
  endtask

  // Also serves as repeated start from a low clock
  task automatic start_cond();
    sda_pull = 1'b0;
    #31;
    scl = 1'b1;
    #31;
    sda_pull = 1'b1;
    #31;
    scl = 1'b0;
    #31;
  endtask

  task automatic stop_cond();
    sda_pull = 1'b1;
    #31;
    scl = 1'b1;
    #31;
    sda_pull = 1'b0;
    #31;
  endtask

  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic rd(input logic mack);
    logic       r;
    logic [7:0] d;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~mack, r);
    rx_byte = d;
    ->rx_ev;
  endtask
endmodule

// ---- thcd_decoder.sv ----
// Two-wire slave command decoder with conversion control and config storage.
// Assumes scl and sda_i come from an open-drain bus; sda_oe high pulls the wire.
// temp_in is a result word from converter logic on mclk.
`timescale 1ns/1ns
module thcd_decoder
  import thcd_pkg::*;
#(
  parameter logic [3:0] DEVICE_CODE = DEV_CODE,
  parameter int         PROG_LEN    = PROG_CYCLES,
  parameter int         CONV_LEN    = CONV_CYCLES
)
(
  input  logic              mclk,
  input  logic              reset,
  input  logic              scl,
  input  logic              sda_i,
  output logic              sda_o,
  output logic              sda_oe,
  input  logic [2:0]        addr_pins,
  input  logic [TEMP_W-1:0] temp_in,
  output logic              conv_active,
  output logic              prog_active,
  output logic [7:0]        mem_ptr
);

  localparam int PW = $clog2(PROG_LEN + 1);
  localparam int CW = $clog2(CONV_LEN + 1);

  // Reset view of config and result, shared by the core copy and the link snapshot
  localparam thcd_pub_t PUB_RST = '{cfg:  {1'b1, CFG_FIXED, CFG_MODE_RST},
                                    temp: {TEMP_RST, 3'b000}};

  // The programming-window check needs at least 8 busy cycles
  generate
    if (PROG_LEN < 8 || CONV_LEN < 2)
    begin : g_bad
      $error("thcd_decoder: programming length below 8 or conversion length below 2");
    end
  endgenerate

  // ==========================================================
  // Link side: START detection on the data line
  // Flop clocked by sda falling; cleared once scl has clocked it in
  logic        start_det;
  logic        start_clr;
  wire         start_rst = start_clr | reset;

  always_ff @(negedge sda_i or posedge start_rst)
  begin
    if (start_rst)
      start_det <= 1'b0;
    else if (scl)
      start_det <= 1'b1;
  end

  always_ff @(negedge scl or posedge reset)
  begin
    if (reset)
      start_clr <= 1'b0;
    else
      start_clr <= start_det;
  end

  // ==========================================================
  // Link side: synchronisers from mclk and from the pins
  logic        busy_s1;
  logic        busy_s2;
  logic [2:0]  addr_s1;
  logic [2:0]  addr_s2;
  logic        pub_s1;
  logic        pub_s2;
  logic        pub_ack;
  logic        prog_busy;
  logic        pub_tgl;
  thcd_pub_t   pub;
  thcd_pub_t   snap;

  always_ff @(posedge scl or posedge reset)
  begin
    if (reset)
    begin
      busy_s1 <= 1'b0;
      busy_s2 <= 1'b0;
      addr_s1 <= 3'h0;
      addr_s2 <= 3'h0;
      pub_s1  <= 1'b0;
      pub_s2  <= 1'b0;
    end
    else
    begin
      busy_s1 <= prog_busy;
      busy_s2 <= busy_s1;
      addr_s1 <= addr_pins;
      addr_s2 <= addr_s1;
      pub_s1  <= pub_tgl;
      pub_s2  <= pub_s1;
    end
  end

  // Snapshot is taken only while pub is frozen by the handshake
  always_ff @(posedge scl or posedge reset)
  begin
    if (reset)
    begin
      pub_ack <= 1'b0;
      snap    <= PUB_RST;
    end
    else if (pub_s2 != pub_ack)
    begin
      pub_ack <= pub_s2;
      snap    <= pub;
    end
  end

  // ==========================================================
  // Link side: byte engine
  thcd_phase_t phase;
  thcd_event_t ev_out;
  logic        ev_tgl;
  logic [3:0]  bit_cnt;
  logic [6:0]  shreg;
  logic [7:0]  last_cmd;
  logic        ack_pend;
  logic        tx_idx;

  wire [7:0] rx_byte  = {shreg, sda_i};
  wire       byte_end = (bit_cnt == LAST_BIT) && !start_clr;
  wire       ack_clk  = (bit_cnt == ACK_BIT) && !start_clr;
  wire       addr_hit = (rx_byte[7:1] == {DEVICE_CODE, addr_s2}) && !busy_s2;
  wire       is_go    = (rx_byte == CMD_GO);
  wire       is_halt  = (rx_byte == CMD_HALT);
  wire       is_wcmd  = (rx_byte == CMD_MEM) || (rx_byte == CMD_CFG);
  wire       ack_now  = (phase == P_ADDR) ? addr_hit :
                        (phase != P_TX) && (phase != P_IGN);
  wire       ev_fire  = byte_end &&
                        ((phase == P_CMD && (is_go || is_halt)) || phase == P_WDATA);
  wire thcd_ev_t ev_kind = (phase == P_WDATA) ?
                           ((last_cmd == CMD_MEM) ? EV_PTR : EV_CFG) :
                           (is_go ? EV_GO : EV_HALT);

  always_ff @(posedge scl or posedge reset)
  begin
    if (reset)
      bit_cnt <= 4'h0;
    else if (start_clr)
      bit_cnt <= 4'h1;
    else if (bit_cnt == ACK_BIT)
      bit_cnt <= 4'h0;
    else
      bit_cnt <= bit_cnt + 4'h1;
  end

  always_ff @(posedge scl or posedge reset)
  begin
    if (reset)
      shreg <= 7'h00;
    else
      shreg <= rx_byte[6:0];
  end

  always_ff @(posedge scl or posedge reset)
  begin
    if (reset)
    begin
      phase    <= P_ADDR;
      ack_pend <= 1'b0;
      last_cmd <= 8'h00;
      tx_idx   <= 1'b0;
    end
    else if (start_clr)
    begin
      phase    <= P_ADDR;
      ack_pend <= 1'b0;
    end
    else if (byte_end)
    begin
      ack_pend <= ack_now;
      case (phase)
        P_ADDR:
        begin
          tx_idx <= 1'b0;
          if (!addr_hit)
            phase <= P_IGN;
          else if (rx_byte[0])
            phase <= P_TX;
          else
            phase <= P_CMD;
        end
        P_CMD:
        begin
          last_cmd <= rx_byte;
          phase    <= is_wcmd ? P_WDATA : P_HOLD;
        end
        P_WDATA:
          phase <= P_HOLD;
        default:
          phase <= phase;
      endcase
    end
    // The address ack is our own; only the master's acks after data step the index
    else if (ack_clk && phase == P_TX && !ack_pend)
    begin
      if (sda_i)
        phase <= P_IGN;
      else
        tx_idx <= ~tx_idx;
    end
  end

  // Event word stays put until the next command byte, far past the sync delay
  always_ff @(posedge scl or posedge reset)
  begin
    if (reset)
    begin
      ev_tgl <= 1'b0;
      ev_out <= '0;
    end
    else if (ev_fire)
    begin
      ev_tgl <= ~ev_tgl;
      ev_out <= '{kind: ev_kind, data: rx_byte};
    end
  end

  // Reads return config for the config code, else the result MSB then LSB
  wire [7:0] tx_byte = (last_cmd == CMD_CFG) ? snap.cfg :
                       (tx_idx ? snap.temp[7:0] : snap.temp[15:8]);
  wire [2:0] tx_sel  = 3'h7 - bit_cnt[2:0];

  always_ff @(negedge scl or posedge reset)
  begin
    if (reset)
      sda_oe <= 1'b0;
    else if (start_det)
      sda_oe <= 1'b0;
    else if (bit_cnt == ACK_BIT)
      sda_oe <= ack_pend;
    else if (phase == P_TX)
      sda_oe <= ~tx_byte[tx_sel];
    else
      sda_oe <= 1'b0;
  end

  assign sda_o = 1'b0;

  // ==========================================================
  // Core side: event receive and crossing back
  logic        ev_s1;
  logic        ev_s2;
  logic        ev_s3;
  logic        ack_s1;
  logic        ack_s2;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ev_s1  <= 1'b0;
      ev_s2  <= 1'b0;
      ev_s3  <= 1'b0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end
    else
    begin
      ev_s1  <= ev_tgl;
      ev_s2  <= ev_s1;
      ev_s3  <= ev_s2;
      ack_s1 <= pub_ack;
      ack_s2 <= ack_s1;
    end
  end

  wire ev_hit  = ev_s2 ^ ev_s3;
  wire ev_ptr  = ev_hit && (ev_out.kind == EV_PTR);
  wire ev_cfg  = ev_hit && (ev_out.kind == EV_CFG);
  wire ev_go   = ev_hit && (ev_out.kind == EV_GO);
  wire ev_halt = ev_hit && (ev_out.kind == EV_HALT);

  // ==========================================================
  // Core side: configuration, pointer and programming timer
  logic          mode;
  logic [PW-1:0] prog_cnt;

  assign prog_busy = (prog_cnt != '0);

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      mode     <= CFG_MODE_RST;
      mem_ptr  <= 8'h00;
      prog_cnt <= '0;
    end
    else if (ev_cfg)
    begin
      mode     <= ev_out.data[CFG_MODE_BIT];
      prog_cnt <= PW'(PROG_LEN);
    end
    else
    begin
      if (ev_ptr)
        mem_ptr <= ev_out.data;
      if (prog_busy)
        prog_cnt <= prog_cnt - PW'(1);
    end
  end

  // ==========================================================
  // Core side: conversion control
  thcd_conv_t        conv_st;
  logic [CW-1:0]     conv_cnt;
  logic              halt_pend;
  logic [TEMP_W-1:0] temp;

  wire conv_run = (conv_st == C_RUN);
  wire conv_end = conv_run && (conv_cnt == '0);
  wire stop_now = mode || halt_pend || ev_halt;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      conv_st   <= C_IDLE;
      conv_cnt  <= '0;
      halt_pend <= 1'b0;
      temp      <= TEMP_RST;
    end
    else
    begin
      case (conv_st)
        C_IDLE:
          if (ev_go)
          begin
            conv_st   <= C_RUN;
            conv_cnt  <= CW'(CONV_LEN - 1);
            halt_pend <= 1'b0;
          end
        C_RUN:
          if (conv_end)
          begin
            temp     <= temp_in;
            conv_cnt <= CW'(CONV_LEN - 1);
            if (stop_now && !ev_go)
              conv_st <= C_IDLE;
            halt_pend <= 1'b0;
          end
          else
          begin
            conv_cnt <= conv_cnt - CW'(1);
            if (ev_halt)
              halt_pend <= 1'b1;
            else if (ev_go)
              halt_pend <= 1'b0;
          end
        default:
          conv_st <= C_IDLE;
      endcase
    end
  end

  // Unknown codes never raise an event, so nothing here moves

  // ==========================================================
  // Core side: publish config and result to the link
  wire [7:0] cfg_view = {~conv_run, CFG_FIXED, mode};
  wire thcd_pub_t live = '{cfg: cfg_view, temp: {temp, 3'b000}};

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pub_tgl <= 1'b0;
      pub     <= PUB_RST;
    end
    else if (pub_tgl == ack_s2 && pub != live)
    begin
      pub     <= live;
      pub_tgl <= ~pub_tgl;
    end
  end

  assign conv_active = conv_run;
  assign prog_active = prog_busy;

  // ==========================================================
  // Checks
  chk_cfg_store: assert property (@(posedge mclk) disable iff (reset)
    ev_cfg |=> mode == $past(ev_out.data[0]))
    else $error("config mode bit not stored");

  chk_prog_window: assert property (@(posedge mclk) disable iff (reset)
    ev_cfg |=> prog_busy [*8])
    else $error("programming cycle ended early");

  chk_ptr_load: assert property (@(posedge mclk) disable iff (reset)
    ev_ptr && !ev_cfg |=> mem_ptr == $past(ev_out.data))
    else $error("word pointer not loaded");

  chk_go_starts: assert property (@(posedge mclk) disable iff (reset)
    ev_go && !conv_run |=> conv_run && conv_cnt == CW'(CONV_LEN - 1))
    else $error("begin command did not start a conversion");

  chk_single_stop: assert property (@(posedge mclk) disable iff (reset)
    conv_end && mode && !ev_go |=> !conv_run)
    else $error("single mode kept converting");

  chk_cont_runs: assert property (@(posedge mclk) disable iff (reset)
    conv_end && !mode && !halt_pend && !ev_halt |=> conv_run)
    else $error("continuous mode stopped");

  chk_halt_finish: assert property (@(posedge mclk) disable iff (reset)
    ev_halt && conv_run && !conv_end |=> conv_run ##0 halt_pend)
    else $error("halt aborted the running conversion");

  chk_temp_load: assert property (@(posedge mclk) disable iff (reset)
    conv_end |=> temp == $past(temp_in))
    else $error("result not taken at conversion end");

  chk_done_flag: assert property (@(posedge mclk) disable iff (reset)
    $rose(conv_run) |-> !cfg_view[CFG_DONE_BIT] ##1 !cfg_view[CFG_DONE_BIT])
    else $error("done flag high during conversion");

  chk_busy_nack: assert property (@(posedge scl) disable iff (reset)
    byte_end && phase == P_ADDR && busy_s2 |=> !ack_pend && phase == P_IGN)
    else $error("access acknowledged while programming");

  chk_unknown_cmd: assert property (@(posedge scl) disable iff (reset)
    byte_end && phase == P_CMD && !is_go && !is_halt |=> $stable(ev_tgl))
    else $error("undefined command raised an event");

  cov_single_conv: cover property (@(posedge mclk) disable iff (reset)
    conv_end && mode);
  cov_halt_cont: cover property (@(posedge mclk) disable iff (reset)
    ev_halt && conv_run && !mode);
  cov_cfg_write: cover property (@(posedge mclk) disable iff (reset)
    ev_cfg);
  cov_temp_read: cover property (@(posedge scl) disable iff (reset)
    ack_clk && phase == P_TX && tx_idx);

endmodule

// ---- thcd_pkg.sv ----
// Constants, codes and carrier types of the thermometer command decoder.
// Assumes a 50 MHz mclk and a two-wire bus clock coming from the bus master.
package thcd_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_HZ       = 50_000_000;
  localparam int PROG_TIME_US = 10_000;
  localparam int PROG_CYCLES  = PROG_TIME_US * (CLK_HZ / 1_000_000);
  localparam int CONV_CYCLES  = 4000;

  // ==========================================================
  // Bus address and command codes
  // Device code value is arbitrary
  localparam logic [3:0] DEV_CODE = 4'h5;
  localparam logic [7:0] CMD_MEM  = 8'h17;
  localparam logic [7:0] CMD_CFG  = 8'hac;
  localparam logic [7:0] CMD_TEMP = 8'haa;
  localparam logic [7:0] CMD_GO   = 8'hee;
  localparam logic [7:0] CMD_HALT = 8'h22;

  // ==========================================================
  // Configuration layout
  localparam int         CFG_DONE_BIT = 7;
  localparam int         CFG_MODE_BIT = 0;
  localparam logic [5:0] CFG_FIXED    = 6'h25;
  localparam logic       CFG_MODE_RST = 1'b0;
  localparam int         TEMP_W       = 13;
  localparam logic [12:0] TEMP_RST    = 13'h0000;
  localparam logic [3:0] ACK_BIT      = 4'h8;
  localparam logic [3:0] LAST_BIT     = 4'h7;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    P_ADDR  = 3'b000,
    P_CMD   = 3'b001,
    P_WDATA = 3'b011,
    P_HOLD  = 3'b010,
    P_TX    = 3'b110,
    P_IGN   = 3'b111
  } thcd_phase_t;

  typedef enum logic {
    C_IDLE = 1'b0,
    C_RUN  = 1'b1
  } thcd_conv_t;

  typedef enum logic [1:0] {
    EV_PTR  = 2'b00,
    EV_CFG  = 2'b01,
    EV_GO   = 2'b11,
    EV_HALT = 2'b10
  } thcd_ev_t;

  typedef struct packed {
    thcd_ev_t   kind;
    logic [7:0] data;
  } thcd_event_t;

  typedef struct packed {
    logic [7:0]  cfg;
    logic [15:0] temp;
  } thcd_pub_t;

endpackage
